// >>> dsac_core.v
// digital core of a delta-sigma converter with a wishbone register slave
`include "dsac_map.vh"

// Operation
// R1: result as 24-bit or 32-bit word
// R2: output rates from 250 to 4000 samples
// R3: sinc5, decimate-by-32 fir, then high-pass
// R4: output taken from sinc, fir or high-pass
// R5: gain multiply and offset add calibrate result
// R6: mode pin picks pin or register control
// R7: sync resets filter and modulator timing
// R8: toggling sync frame clock keeps alignment
// R9: reset pin restores registers, restarts conversion
// R10: power-down low loses registers, stops core
// R11: standby bit lowers power, keeps registers
// R12: reset and sync qualified against clock
// R13: host reads results and accesses registers
// R14: merge bitstreams with fixed weighted taps
// R15: raw mode disables filter, drives pins
// R16: over-range flag follows modulator overdrive
// R17: linear after 31, settled after 62
// R18: saturation exit 12 mod clocks, then 62
// R19: chopper runs at clock over 512
// R20: flag sampled at half modulator rate
// R21: path field 00 selects raw mode
// R22: 24-bit word is top 24 bits
// R23: scaled result saturates, never wraps
module dsac_core (
  clk_sys,
  rst_b,
  wb_cyc_i,
  wb_stb_i,
  wb_we_i,
  wb_adr_i,
  wb_sel_i,
  wb_dat_i,
  wb_dat_o,
  wb_ack_o,
  control_mode_select,
  power_down_n,
  reset_pin_n,
  hpf_sync_pin,
  bypass_pin,
  first_stage_bitstream,
  second_stage_bitstream,
  comparator_i,
  mclk_pin_i,
  mclk_pin_o,
  mclk_pin_oe,
  bs0_pin_i,
  bs0_pin_o,
  bs0_pin_oe,
  bs1_pin_i,
  bs1_pin_o,
  bs1_pin_oe,
  overrange_flag,
  chopper_clk,
  filter_active,
  result_data,
  result_valid
);
  input         clk_sys;
  input         rst_b;
  input         wb_cyc_i;
  input         wb_stb_i;
  input         wb_we_i;
  input  [7:0]  wb_adr_i;
  input  [3:0]  wb_sel_i;
  input  [31:0] wb_dat_i;
  output [31:0] wb_dat_o;
  output        wb_ack_o;
  input         control_mode_select;
  input         power_down_n;
  input         reset_pin_n;
  input         hpf_sync_pin;
  input         bypass_pin;
  input         first_stage_bitstream;
  input         second_stage_bitstream;
  input         comparator_i;
  input         mclk_pin_i;
  output        mclk_pin_o;
  output        mclk_pin_oe;
  input         bs0_pin_i;
  output        bs0_pin_o;
  output        bs0_pin_oe;
  input         bs1_pin_i;
  output        bs1_pin_o;
  output        bs1_pin_oe;
  output        overrange_flag;
  output        chopper_clk;
  output        filter_active;
  output [31:0] result_data;
  output        result_valid;

  localparam CW = 44;

  // clip a wide signed sum to the 32-bit code range
  function [31:0] sat32;
    input [34:0] v;
    begin
      if (!v[34] && (v[33:31] != 3'b000))
        sat32 = 32'h7fffffff;
      else if (v[34] && (v[33:31] != 3'b111))
        sat32 = 32'h80000000;
      else
        sat32 = v[31:0];
    end
  endfunction

  // byte-lane merge of a wishbone write
  function [31:0] lanes;
    input [31:0] old;
    input [31:0] wd;
    input [3:0]  sel;
    begin
      lanes[7:0]   = sel[0] ? wd[7:0]   : old[7:0];
      lanes[15:8]  = sel[1] ? wd[15:8]  : old[15:8];
      lanes[23:16] = sel[2] ? wd[23:16] : old[23:16];
      lanes[31:24] = sel[3] ? wd[31:24] : old[31:24];
    end
  endfunction

  reg  [10:0]   meta_ff;
  reg  [10:0]   sync_ff;
  reg  [`DSAC_QUAL_LEN-1:0] rhist_ff;
  reg  [`DSAC_QUAL_LEN-1:0] shist_ff;
  reg           rlvl_ff;
  reg           slvl_ff;
  reg           sprev_ff;
  reg  [7:0]    cfg_ff;
  reg  [4:0]    hpfk_ff;
  reg  [31:0]   offset_ff;
  reg  [31:0]   gain_ff;
  reg  [1:0]    mod_cnt_ff;
  reg           mclk_ff;
  reg           tick_d_ff;
  reg  [4:0]    m0_h_ff;
  reg  [2:0]    m1_h_ff;
  reg  [8:0]    chop_cnt_ff;
  reg           chop_ff;
  reg  [CW-1:0] int_ff [0:4];
  reg  [CW-1:0] z_ff [0:4];
  reg  [CW-1:0] cmb [0:5];
  reg  [6:0]    dec_cnt_ff;
  reg  [31:0]   sinc_ff;
  reg           sinc_v_ff;
  reg  [36:0]   fir_acc_ff;
  reg  [4:0]    fir_cnt_ff;
  reg  [31:0]   fir_ff;
  reg  [31:0]   fir_prev_ff;
  reg           fir_v_ff;
  reg  [32:0]   dc_ff;
  reg  [31:0]   res_ff;
  reg  [31:0]   res_out_ff;
  reg           res_v_ff;
  reg           ready_ff;
  reg           ovr_div_ff;
  reg           ovr_ff;
  reg  [3:0]    sat_cnt_ff;
  reg  [5:0]    rd_cnt_ff;
  reg  [31:0]   wb_dat_ff;
  reg           wb_ack_ff;
  reg  [7:0]    y;
  reg  [31:0]   st_d;
  reg  [31:0]   rdata;
  integer       i;
  integer       j;

  wire pin_mode = sync_ff[0];
  wire q_pd_n   = sync_ff[1];
  wire q_rst    = sync_ff[2];
  wire q_hs     = sync_ff[3];
  wire q_byp    = sync_ff[4];
  wire q_mclk   = sync_ff[5];
  wire q_bs0    = sync_ff[6];
  wire q_bs1    = sync_ff[7];
  wire q_m0     = sync_ff[8];
  wire q_m1     = sync_ff[9];
  wire q_cmp    = sync_ff[10];

  // two flops on every pin before any logic reads it
  always @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      meta_ff <= 11'h000;
      sync_ff <= 11'h000;
    end
    else
    begin
      meta_ff <= {comparator_i, second_stage_bitstream,
                  first_stage_bitstream, bs1_pin_i, bs0_pin_i, mclk_pin_i,
                  bypass_pin, hpf_sync_pin, reset_pin_n, power_down_n,
                  control_mode_select};
      sync_ff <= meta_ff;
    end
  end

  // in pin mode without bypass the reset pin carries sync, active low
  wire sync_src = (pin_mode && !q_byp) ? !q_rst : q_hs;

  // glitch qualifier: level changes only after stable samples
  always @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      rhist_ff <= {`DSAC_QUAL_LEN{1'b0}};
      shist_ff <= {`DSAC_QUAL_LEN{1'b0}};
      rlvl_ff  <= 1'b0;
      slvl_ff  <= 1'b0;
      sprev_ff <= 1'b0;
    end
    else
    begin
      rhist_ff <= {rhist_ff[`DSAC_QUAL_LEN-2:0], q_rst};
      shist_ff <= {shist_ff[`DSAC_QUAL_LEN-2:0], sync_src};
      if (&rhist_ff || ~|rhist_ff)
        rlvl_ff <= rhist_ff[0]; // R12
      if (&shist_ff || ~|shist_ff)
        slvl_ff <= shist_ff[0]; // R12
      sprev_ff <= slvl_ff;
    end
  end

  // resets: power-down wipes all, reset pin only in register mode
  wire core_rst = !rst_b || !q_pd_n; // R10
  wire reg_rst  = core_rst || (!pin_mode && !rlvl_ff); // R9
  wire aligned;
  wire sync_rise = slvl_ff && !sprev_ff;
  // an edge landing on a conversion boundary is already aligned
  wire restart  = reg_rst || (sync_rise && !aligned); // R7 R8

  // effective control from pins or registers
  wire [1:0] path = pin_mode ?
                    (q_byp ? `DSAC_PATH_RAW :
                     (q_hs ? `DSAC_PATH_HPF : `DSAC_PATH_FIR)) :
                    cfg_ff[`DSAC_CFG_PATH_HI:`DSAC_CFG_PATH_LO]; // R6
  wire [2:0] cfg_rate = cfg_ff[`DSAC_CFG_RATE_HI:`DSAC_CFG_RATE_LO];
  wire [2:0] rate = pin_mode ? {1'b0, q_bs1, q_bs0} :
                    ((cfg_rate > `DSAC_RATE_MAX) ? `DSAC_RATE_MAX :
                     cfg_rate); // R2
  wire min_phase = pin_mode ? q_mclk : cfg_ff[`DSAC_CFG_PHASE];
  wire word32    = pin_mode || cfg_ff[`DSAC_CFG_WORD32];
  wire standby   = !pin_mode && cfg_ff[`DSAC_CFG_STANDBY]; // R11
  wire raw_mode  = (path == `DSAC_PATH_RAW); // R21
  wire run       = !restart && !raw_mode && !standby; // R15
  wire [6:0] dec_last = `DSAC_DEC_BASE >> rate;
  wire integ     = run && tick_d_ff;

  // last cycle of a frame: a sync edge here needs no restart
  assign aligned = (mod_cnt_ff == `DSAC_MOD_LAST) &&
                   (dec_cnt_ff == dec_last) &&
                   (fir_cnt_ff == `DSAC_FIR_LAST); // R8

  wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_ff;
  wire bus_wr  = bus_req && wb_we_i && !pin_mode; // R6 R13
  wire [7:0] bus_ofs = {wb_adr_i[7:2], 2'b00};

  // configuration registers, defaults on reset or power-down
  always @(posedge clk_sys)
  begin
    if (reg_rst)
    begin
      cfg_ff    <= `DSAC_CFG_RST; // R9
      hpfk_ff   <= `DSAC_HPF_RST;
      offset_ff <= `DSAC_OFFSET_RST;
      gain_ff   <= `DSAC_GAIN_RST;
    end
    else if (bus_wr)
    begin
      if (bus_ofs == `DSAC_OFS_CFG && wb_sel_i[0])
        cfg_ff <= wb_dat_i[7:0];
      if (bus_ofs == `DSAC_OFS_HPF && wb_sel_i[0])
        hpfk_ff <= wb_dat_i[4:0];
      if (bus_ofs == `DSAC_OFS_OFFSET)
        offset_ff <= lanes(offset_ff, wb_dat_i, wb_sel_i);
      if (bus_ofs == `DSAC_OFS_GAIN)
        gain_ff <= lanes(gain_ff, wb_dat_i, wb_sel_i);
    end
  end

  // modulator clock, bit history and chopper timing
  always @(posedge clk_sys)
  begin
    if (restart)
    begin
      mod_cnt_ff  <= 2'h0;
      mclk_ff     <= 1'b0;
      tick_d_ff   <= 1'b0;
      m0_h_ff     <= 5'h00;
      m1_h_ff     <= 3'h0;
      chop_cnt_ff <= 9'h000;
      chop_ff     <= 1'b0;
    end
    else
    begin
      mod_cnt_ff  <= mod_cnt_ff + 2'h1;
      mclk_ff     <= mod_cnt_ff[1];
      tick_d_ff   <= (mod_cnt_ff == `DSAC_MOD_LAST);
      chop_cnt_ff <= chop_cnt_ff + 9'h001;
      chop_ff     <= chop_cnt_ff[8]; // R19
      if (mod_cnt_ff == `DSAC_MOD_LAST)
      begin
        m0_h_ff <= {m0_h_ff[3:0], q_m0};
        m1_h_ff <= {m1_h_ff[1:0], q_m1};
      end
    end
  end

  // merge of the two bitstreams; index 0 is the newest bit
  always @*
  begin
    y = (m0_h_ff[2] ? 8'h03 : 8'h00) - (m0_h_ff[3] ? 8'h06 : 8'h00)
      + (m0_h_ff[4] ? 8'h04 : 8'h00) + (m1_h_ff[0] ? 8'h09 : 8'h00)
      - (m1_h_ff[1] ? 8'h12 : 8'h00) + (m1_h_ff[2] ? 8'h09 : 8'h00); // R14
  end

  // sinc5 comb chain on the last integrator
  always @*
  begin
    cmb[0] = int_ff[4];
    for (j = 0; j < 5; j = j + 1)
      cmb[j+1] = cmb[j] - z_ff[j];
  end

  wire [CW-1:0] norm = cmb[5] << ({2'b00, rate, 2'b00} + {4'h0, rate});

  // sinc5 integrators and decimator
  always @(posedge clk_sys)
  begin
    if (restart || raw_mode)
    begin
      for (i = 0; i < 5; i = i + 1)
      begin
        int_ff[i] <= {CW{1'b0}};
        z_ff[i]   <= {CW{1'b0}};
      end
      dec_cnt_ff <= 7'h00;
      sinc_ff    <= 32'h00000000;
      sinc_v_ff  <= 1'b0;
    end
    else
    begin
      sinc_v_ff <= 1'b0;
      if (integ)
      begin
        int_ff[0] <= int_ff[0] + {{(CW-8){y[7]}}, y}; // R3
        for (i = 1; i < 5; i = i + 1)
          int_ff[i] <= int_ff[i] + int_ff[i-1];
        if (dec_cnt_ff >= dec_last)
        begin
          dec_cnt_ff <= 7'h00;
          for (i = 0; i < 5; i = i + 1)
            z_ff[i] <= cmb[i];
          sinc_ff   <= norm[40:9];
          sinc_v_ff <= 1'b1;
        end
        else
          dec_cnt_ff <= dec_cnt_ff + 7'h01;
      end
    end
  end

  // fir low-pass: block average over 32 sinc words
  wire [36:0] fir_sum = fir_acc_ff + {{5{sinc_ff[31]}}, sinc_ff};
  wire [36:0] fir_avg = fir_sum >> `DSAC_FIR_SHIFT;
  wire [31:0] fir_new = {fir_sum[36], fir_avg[30:0]};
  wire [31:0] fir_out = min_phase ? fir_ff : fir_prev_ff;
  wire [32:0] hp_diff = {fir_out[31], fir_out} - dc_ff;
  wire [32:0] hp_step = $signed(hp_diff) >>> hpfk_ff;

  always @(posedge clk_sys)
  begin
    if (restart || raw_mode)
    begin
      fir_acc_ff  <= 37'h0;
      fir_cnt_ff  <= 5'h00;
      fir_ff      <= 32'h00000000;
      fir_prev_ff <= 32'h00000000;
      fir_v_ff    <= 1'b0;
      dc_ff       <= 33'h0;
    end
    else
    begin
      fir_v_ff <= 1'b0;
      if (sinc_v_ff && !standby)
      begin
        if (fir_cnt_ff == `DSAC_FIR_LAST)
        begin
          fir_acc_ff  <= 37'h0;
          fir_ff      <= fir_new; // R3
          fir_prev_ff <= fir_ff;
          fir_v_ff    <= 1'b1;
        end
        else
          fir_acc_ff <= fir_sum;
        fir_cnt_ff <= fir_cnt_ff + 5'h01;
      end
      if (fir_v_ff && path == `DSAC_PATH_HPF)
        dc_ff <= dc_ff + hp_step; // R3
    end
  end

  // stage select feeding the calibration multiplier
  always @*
  begin
    case (path)
      `DSAC_PATH_SINC: st_d = sinc_ff; // R4
      `DSAC_PATH_HPF:  st_d = sat32({{2{hp_diff[32]}}, hp_diff});
      default:         st_d = fir_out;
    endcase
  end

  wire        st_v = (path == `DSAC_PATH_SINC) ? sinc_v_ff :
                     (fir_v_ff && !raw_mode);
  wire [63:0] prod = $signed(st_d) * $signed(gain_ff); // R5
  wire [34:0] scaled = {prod[63], prod[63:30]} +
                       {{3{offset_ff[31]}}, offset_ff}; // R5
  wire [31:0] clip = sat32(scaled); // R23

  // scaled result and the word presented to the host
  always @(posedge clk_sys)
  begin
    if (restart)
    begin
      res_ff     <= 32'h00000000;
      res_out_ff <= 32'h00000000;
      res_v_ff   <= 1'b0;
    end
    else
    begin
      res_v_ff <= st_v;
      if (st_v)
      begin
        res_ff     <= clip;
        res_out_ff <= word32 ? clip : {8'h00, clip[31:8]}; // R1 R22
      end
    end
  end

  // over-range flag and recovery tracking
  always @(posedge clk_sys)
  begin
    if (core_rst)
    begin
      ovr_div_ff <= 1'b0;
      ovr_ff     <= 1'b0;
      sat_cnt_ff <= 4'h0;
      rd_cnt_ff  <= 6'h00;
    end
    else
    begin
      if (tick_d_ff)
        ovr_div_ff <= !ovr_div_ff;
      if (tick_d_ff && ovr_div_ff)
        ovr_ff <= q_cmp; // R16 R20
      if (ovr_ff)
      begin
        sat_cnt_ff <= `DSAC_SAT_EXIT; // R18
        rd_cnt_ff  <= 6'h00;
      end
      else if (sat_cnt_ff != 4'h0)
      begin
        if (tick_d_ff)
          sat_cnt_ff <= sat_cnt_ff - 4'h1; // R18
      end
      else if (res_v_ff && rd_cnt_ff < `DSAC_SETTLE_READS)
        rd_cnt_ff <= rd_cnt_ff + 6'h01; // R17
    end
  end

  wire linear  = !ovr_ff && (sat_cnt_ff == 4'h0) &&
                 (rd_cnt_ff >= `DSAC_LIN_READS); // R17
  wire settled = linear && (rd_cnt_ff >= `DSAC_SETTLE_READS); // R17
  wire rd_res  = bus_req && !wb_we_i && (bus_ofs == `DSAC_OFS_RESULT);

  // read mux; unmapped offsets read zero
  always @*
  begin
    rdata = 32'h00000000;
    case (bus_ofs)
      `DSAC_OFS_CFG:    rdata = {24'h000000, cfg_ff};
      `DSAC_OFS_HPF:    rdata = {27'h0000000, hpfk_ff};
      `DSAC_OFS_OFFSET: rdata = offset_ff;
      `DSAC_OFS_GAIN:   rdata = gain_ff;
      `DSAC_OFS_RESULT: rdata = res_out_ff; // R13
      `DSAC_OFS_STATUS: rdata = {28'h0000000, ready_ff, settled, linear,
                                 ovr_ff};
      default:          rdata = 32'h00000000;
    endcase
  end

  // wishbone answer one cycle after the request; new data wins a read
  always @(posedge clk_sys)
  begin
    if (core_rst)
    begin
      wb_ack_ff <= 1'b0;
      wb_dat_ff <= 32'h00000000;
      ready_ff  <= 1'b0;
    end
    else
    begin
      wb_ack_ff <= bus_req;
      if (bus_req && !wb_we_i)
        wb_dat_ff <= rdata; // R13
      if (res_v_ff)
        ready_ff <= 1'b1;
      else if (rd_res)
        ready_ff <= 1'b0;
    end
  end

  assign wb_dat_o      = wb_dat_ff;
  assign wb_ack_o      = wb_ack_ff;
  assign mclk_pin_o    = mclk_ff;
  assign mclk_pin_oe   = raw_mode; // R15
  assign bs0_pin_o     = m0_h_ff[0];
  assign bs0_pin_oe    = raw_mode;
  assign bs1_pin_o     = m1_h_ff[0];
  assign bs1_pin_oe    = raw_mode;
  assign overrange_flag = ovr_ff;
  assign chopper_clk   = chop_ff;
  assign filter_active = run;
  assign result_data   = res_out_ff;
  assign result_valid  = res_v_ff;

endmodule

// >>> dsac_map.vh
// offsets, field positions, reset values and counts of the converter core
`ifndef DSAC_MAP_VH
`define DSAC_MAP_VH

// register byte offsets
`define DSAC_OFS_CFG      8'h00
`define DSAC_OFS_HPF      8'h04
`define DSAC_OFS_OFFSET   8'h08
`define DSAC_OFS_GAIN     8'h0c
`define DSAC_OFS_RESULT   8'h10
`define DSAC_OFS_STATUS   8'h14

// first_config_register fields
`define DSAC_CFG_PATH_LO  0
`define DSAC_CFG_PATH_HI  1
`define DSAC_CFG_RATE_LO  2
`define DSAC_CFG_RATE_HI  4
`define DSAC_CFG_PHASE    5
`define DSAC_CFG_WORD32   6
`define DSAC_CFG_STANDBY  7

// status fields
`define DSAC_ST_OVR       0
`define DSAC_ST_LINEAR    1
`define DSAC_ST_SETTLED   2
`define DSAC_ST_READY     3

// reset values
`define DSAC_CFG_RST      8'h42
`define DSAC_HPF_RST      5'h0a
`define DSAC_OFFSET_RST   32'h00000000
`define DSAC_GAIN_RST     32'h40000000

// filter path codes
`define DSAC_PATH_RAW     2'b00
`define DSAC_PATH_SINC    2'b01
`define DSAC_PATH_FIR     2'b10
`define DSAC_PATH_HPF     2'b11

// counts
`define DSAC_MOD_LAST     2'h3
`define DSAC_RATE_MAX     3'h4
`define DSAC_DEC_BASE     7'h7f
`define DSAC_FIR_LAST     5'h1f
`define DSAC_FIR_SHIFT    5
`define DSAC_SAT_EXIT     4'hc
`define DSAC_LIN_READS    6'h1f
`define DSAC_SETTLE_READS 6'h3e
`define DSAC_QUAL_LEN     3

`endif

// >>> dsac_core_asserts.sv
// port-level assertions for the converter core
module dsac_core_asserts (
  input logic        clk_sys,
  input logic        rst_b,
  input logic        power_down_n,
  input logic        reset_pin_n,
  input logic        wb_cyc_i,
  input logic        wb_stb_i,
  input logic        wb_we_i,
  input logic        wb_ack_o,
  input logic [31:0] wb_dat_o,
  input logic        comparator_i,
  input logic        overrange_flag,
  input logic        result_valid,
  input logic        filter_active,
  input logic        mclk_pin_oe,
  input logic        bs0_pin_oe,
  input logic        bs1_pin_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] hi_ff;
  logic [4:0] lo_ff;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // saturating run lengths of the comparator level
  always @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      hi_ff <= 5'h00;
      lo_ff <= 5'h00;
    end
    else
    begin
      hi_ff <= comparator_i ? hi_ff + {4'h0, hi_ff != 5'h1f} : 5'h00;
      lo_ff <= comparator_i ? 5'h00 : lo_ff + {4'h0, lo_ff != 5'h1f};
    end
  end
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  rdata_hold_a: assert property (disable iff (!rst_b || !power_down_n || !reset_pin_n)
    $changed(wb_dat_o) |-> wb_ack_o && !wb_we_i) else $error("read data moved");
  raw_quiet_a: assert property (bs0_pin_oe && $past(bs0_pin_oe) |-> !result_valid)
    else $error("result in raw mode");
  raw_stop_a: assert property (bs0_pin_oe |-> !filter_active)
    else $error("filter running in raw mode");
  oe_same_a: assert property (mclk_pin_oe == bs0_pin_oe && bs1_pin_oe == bs0_pin_oe)
    else $error("pin enables disagree");
  res_gap_a: assert property (result_valid |=> (!result_valid) [*8])
    else $error("results too close");
  ovr_set_a: assert property (hi_ff >= 5'd24 |-> overrange_flag)
    else $error("flag missing in over-range");
  ovr_clr_a: assert property (overrange_flag |-> lo_ff < 5'd24)
    else $error("flag stuck after over-range");
  pd_quiet_a: assert property ((!power_down_n) [*4] |-> !filter_active && !result_valid)
    else $error("core active in power down");
  cover property (result_valid);
  cover property ($rose(overrange_flag));
  cover property (bs0_pin_oe);
  cover property (wb_ack_o && !wb_we_i);
endmodule

bind dsac_core dsac_core_asserts u_chk (.*);

// >>> dsac_mod_model.sv
// modulator and strap-pin side model feeding the converter core
module dsac_mod_model (
  input  wire logic       clk_sys,
  input  wire logic       noisy,
  input  wire logic       overdrive,
  input  wire logic [2:0] pin_lvl,
  input  wire logic       mclk_pin_o,
  input  wire logic       mclk_pin_oe,
  input  wire logic       bs0_pin_o,
  input  wire logic       bs0_pin_oe,
  input  wire logic       bs1_pin_o,
  input  wire logic       bs1_pin_oe,
  output wire logic       first_stage_bitstream,
  output wire logic       second_stage_bitstream,
  output wire logic       comparator_i,
  output wire logic       mclk_pin_i,
  output wire logic       bs0_pin_i,
  output wire logic       bs1_pin_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] lfsr_ff = 16'hace1;
  logic [1:0]  tick_ff = 2'h0;
  logic        bit0_ff = 1'b0;
  logic        bit1_ff = 1'b0;
  // both bits of a tick change together, every four clocks; overdrive saturates
  always @(posedge clk_sys)
  begin
    tick_ff <= tick_ff + 2'h1;
    if (tick_ff == 2'h3)
    begin
      lfsr_ff <= {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12]};
      bit0_ff <= (noisy & ~overdrive) ? lfsr_ff[0] : 1'b1;
      bit1_ff <= noisy & ~overdrive & lfsr_ff[7];
    end
  end
  // comparator tracks overdrive; pins follow whoever drives them
  assign first_stage_bitstream = bit0_ff;
  assign second_stage_bitstream = bit1_ff;
  assign comparator_i = overdrive;
  assign mclk_pin_i = mclk_pin_oe ? mclk_pin_o : pin_lvl[2];
  assign bs1_pin_i = bs1_pin_oe ? bs1_pin_o : pin_lvl[1];
  assign bs0_pin_i = bs0_pin_oe ? bs0_pin_o : pin_lvl[0];
endmodule

// >>> tb_dsac_core.sv
// self-checking bench for the converter core
module tb_dsac_core;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys, rst_b, wb_cyc_i, wb_stb_i, wb_we_i;
  logic        control_mode_select, power_down_n, reset_pin_n;
  logic        hpf_sync_pin, bypass_pin, noisy, overdrive;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, off_v;
  logic [2:0]  pin_lvl;
  wire  [31:0] wb_dat_o, result_data;
  wire         wb_ack_o, mclk_pin_o, mclk_pin_oe, bs0_pin_o, bs0_pin_oe;
  wire         bs1_pin_o, bs1_pin_oe, overrange_flag, chopper_clk;
  wire         filter_active, result_valid, first_stage_bitstream;
  wire         second_stage_bitstream, comparator_i, mclk_pin_i;
  wire         bs0_pin_i, bs1_pin_i;
  logic [63:0] rd_q[$];
  logic [63:0] rd_n;
  logic [31:0] res_q[$];
  int          err_total, checks, cyc_cnt, t0, d1, d2, n;

  dsac_core dut (.*);
  dsac_mod_model u_mod (.*);

  // free-running system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // classic single wishbone cycle; a read notes its masked expectation
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [31:0] m);
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    if (!we)
      rd_q.push_back({m, d & m});
    @(posedge clk_sys);
    while (wb_ack_o !== 1'b1) @(posedge clk_sys);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hf, 32'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    wb(1'b0, a, e, 4'hf, m);
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
  endtask

  task automatic wait_res(input int k);
    repeat (k)
    begin
      @(posedge clk_sys);
      while (result_valid !== 1'b1) @(posedge clk_sys);
    end
  endtask

  task automatic gap(input int e);
    wait_res(1);
    t0 = $time / 100;
    wait_res(1);
    check($time / 100 - t0, e);
  endtask

  task automatic expect_res(input logic [31:0] e);
    wait_res(6);
    tick(1);
    res_q.push_back(e);
    res_q.push_back(e);
    while (res_q.size() > 0) @(posedge clk_sys);
  endtask

  task automatic sync_at(input int off, output int d);
    wait_res(1);
    tick(off);
    t0 = $time / 100;
    hpf_sync_pin <= 1'b1;
    tick(8);
    hpf_sync_pin <= 0;
    wait_res(6);
    d = ($time / 100 - t0) % 32;
  endtask

  // oldest note against what appears; cycle ceiling
  always @(posedge clk_sys)
  begin
    cyc_cnt++;
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && rd_q.size() > 0)
    begin
      rd_n = rd_q.pop_front();
      check(wb_dat_o & rd_n[63:32], rd_n[31:0]);
    end
    if (result_valid === 1'b1 && res_q.size() > 0)
      check(result_data, res_q.pop_front());
    if (cyc_cnt == 45000)
    begin
      err_total++;
      results();
    end
  end

  // main sequence
  initial
  begin
    {rst_b, wb_cyc_i, wb_stb_i, wb_we_i, control_mode_select} = 5'h00;
    {hpf_sync_pin, bypass_pin, overdrive, wb_adr_i, wb_sel_i} = 15'h0000;
    {power_down_n, reset_pin_n, noisy, wb_dat_i, pin_lvl} = 38'h0;
    {power_down_n, reset_pin_n, noisy} = 3'h7;
    void'($urandom(91819));
    tick(4);
    rst_b <= 1'b1;
    tick(10);
    rd(8'h00, 32'h42, 32'hff);
    rd(8'h04, 32'h0a, 32'h1f);
    rd(8'h08, 32'h0, 32'hffffffff);
    rd(8'h0c, 32'h40000000, 32'hffffffff);
    rd(8'h20, 32'h0, 32'hffffffff);
    off_v = $urandom();
    wb(1'b1, 8'h0c, off_v, 4'b0101, 32'h0);
    rd(8'h0c, {8'h40, off_v[23:16], 8'h00, off_v[7:0]}, 32'hffffffff);
    @(posedge chopper_clk);
    t0 = $time / 100;
    @(negedge chopper_clk);
    check($time / 100 - t0, 256);
    for (int r = 0; r < 5; r++)
    begin
      wr(8'h00, 32'h41 | 32'(r << 2));
      wait_res(2);
      gap(4 * (128 >> r));
    end
    wr(8'h00, 32'h52);
    wait_res(1);
    gap(1024);
    wr(8'h00, 32'h53);
    wait_res(1);
    gap(1024);
    wr(8'h0c, 32'h0);
    off_v = $urandom();
    wr(8'h08, off_v);
    wr(8'h00, 32'h51);
    expect_res(off_v);
    rd(8'h14, 32'h8, 32'h8);
    rd(8'h10, off_v, 32'hffffffff);
    rd(8'h14, 32'h0, 32'h8);
    wr(8'h00, 32'h11);
    expect_res({8'h00, off_v[31:8]});
    noisy <= 1'b0;
    wr(8'h0c, 32'h40000000);
    wr(8'h08, 32'h7fffffff);
    wr(8'h00, 32'h51);
    expect_res(32'h7fffffff);
    wr(8'h08, 32'h0);
    wr(8'h00, 32'h40);
    tick(20);
    check({bs0_pin_oe, filter_active, bs0_pin_o, bs1_pin_o}, 4'ha);
    @(posedge mclk_pin_o);
    t0 = $time / 100;
    @(posedge mclk_pin_o);
    check($time / 100 - t0, 4);
    noisy <= 1'b1;
    wr(8'h00, 32'h51);
    control_mode_select <= 1'b1;
    pin_lvl <= 3'b011;
    tick(10);
    wr(8'h00, 32'h00);
    wait_res(1);
    gap(2048);
    bypass_pin <= 1'b1;
    tick(10);
    check(bs0_pin_oe, 1'b1);
    bypass_pin <= 1'b0;
    control_mode_select <= 1'b0;
    tick(10);
    rd(8'h00, 32'h51, 32'hff);
    wait_res(1);
    t0 = $time / 100;
    tick(13);
    hpf_sync_pin <= 1'b1;
    tick(1);
    hpf_sync_pin <= 1'b0;
    wait_res(4);
    check(($time / 100 - t0) % 32, 0);
    sync_at(5, d1);
    sync_at(18, d2);
    check(d1, d2);
    hpf_sync_pin <= 1'b1;
    fork
      repeat (5)
      begin
        tick(512);
        hpf_sync_pin <= ~hpf_sync_pin;
      end
      begin
        wait_res(20);
        t0 = $time / 100;
        wait_res(40);
        check($time / 100 - t0, 1280);
      end
    join
    wr(8'h04, 32'h1f);
    reset_pin_n <= 1'b0;
    tick(1);
    reset_pin_n <= 1'b1;
    tick(10);
    rd(8'h04, 32'h1f, 32'h1f);
    reset_pin_n <= 1'b0;
    tick(8);
    reset_pin_n <= 1'b1;
    tick(10);
    rd(8'h04, 32'h0a, 32'h1f);
    wr(8'h08, off_v);
    wr(8'h00, 32'hd1);
    tick(10);
    n = 0;
    repeat (300)
    begin
      @(posedge clk_sys);
      n += int'(result_valid === 1'b1);
    end
    check(n, 0);
    rd(8'h08, off_v, 32'hffffffff);
    power_down_n <= 1'b0;
    tick(10);
    power_down_n <= 1'b1;
    tick(12);
    rd(8'h08, 32'h0, 32'hffffffff);
    wr(8'h00, 32'h51);
    overdrive <= 1'b1;
    tick(40);
    check(overrange_flag, 1'b1);
    rd(8'h14, 32'h1, 32'h1);
    overdrive <= 1'b0;
    tick(30);
    check(overrange_flag, 1'b0);
    wait_res(20);
    rd(8'h14, 32'h0, 32'h2);
    wait_res(20);
    rd(8'h14, 32'h2, 32'h6);
    wait_res(30);
    rd(8'h14, 32'h6, 32'h6);
    tick(4);
    results();
  end
endmodule
